/* rtl/apc_pkg.sv */
package apc_pkg;
  // Clock period and AXI address width
  localparam int CLK_NS = 10;
  localparam int ADDR_W = 8;
  localparam int RES_W = 10;

  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CHAN = 8'h04;
  localparam logic [7:0] OFF_RESULT = 8'h08;
  localparam logic [7:0] OFF_PFM = 8'h0C;
  localparam logic [7:0] OFF_PFT = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;

  // Field positions
  localparam int MODE_EN_BIT = 7;
  localparam int FR_HI = 5;
  localparam int FR_LO = 3;
  localparam int MODE_CMP_BIT = 0;
  localparam int PFM_EN_BIT = 7;
  localparam int PFM_DIR_BIT = 6;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SETTLED_BIT = 1;
  localparam int STAT_PF_BIT = 2;

  // Values after reset
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [1:0] CHAN_RST = 2'h0;
  localparam logic [7:0] PF_RST = 8'h00;

  // Times in ns and their cycle counts; least times round up
  localparam int SETTLE_NS = 14000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int START_DLY_NS = 1000;
  localparam int START_DLY_CYC = (START_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_NS [8] = '{28800, 19200, 14400, 12000, 9600, 6400, 4800, 3200};

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    APC_IDLE = 2'b00,
    APC_START = 2'b01,
    APC_CONV = 2'b10
  } apc_phase_e;

  // Cycles of one conversion for a time selection code
  function automatic logic [11:0] conv_cyc(input logic [2:0] sel);
    return 12'((CONV_NS[sel] + CLK_NS - 1) / CLK_NS);
  endfunction
endpackage

/* rtl/apc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module apc_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic restart,
  input wire logic [2:0] time_sel,
  output logic done,
  output logic busy
);
  apc_pkg::apc_phase_e phase_r;
  logic [11:0] cnt_r;
  logic done_r;

  // Start delay, then back-to-back conversions of the selected length
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r <= apc_pkg::APC_IDLE;
      cnt_r <= 12'h000;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!run) begin
        phase_r <= apc_pkg::APC_IDLE; // Halts in standby or when disabled
      end else if (restart || phase_r == apc_pkg::APC_IDLE) begin
        phase_r <= apc_pkg::APC_START; // Enable span is shorter than a conversion
        cnt_r <= 12'(apc_pkg::START_DLY_CYC - 1);
      end else begin
        case (phase_r)
          apc_pkg::APC_START: begin
            if (cnt_r == 12'h000) begin
              phase_r <= apc_pkg::APC_CONV;
              cnt_r <= apc_pkg::conv_cyc(time_sel) - 12'h001;
            end else begin
              cnt_r <= cnt_r - 12'h001;
            end
          end
          apc_pkg::APC_CONV: begin
            if (cnt_r == 12'h000) begin
              done_r <= 1'b1; // Done to done equals the selected time; the first done also includes the start delay
              cnt_r <= apc_pkg::conv_cyc(time_sel) - 12'h001;
            end else begin
              cnt_r <= cnt_r - 12'h001;
            end
          end
          default: phase_r <= apc_pkg::APC_IDLE;
        endcase
      end
    end
  end

  assign done = done_r;
  assign busy = (phase_r != apc_pkg::APC_IDLE);
endmodule
`default_nettype wire

/* rtl/apc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module apc_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic standby_req,
  input wire logic [9:0] analog_sample,
  output logic conv_end,
  output logic comparator_on,
  output logic [1:0] channel_sel,
  output logic pf_detect
);
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_got_r, w_got_r, ar_got_r, wwait_r, rwait_r;
  logic [7:0] awaddr_q_r, araddr_q_r;
  logic [7:0] wdata_q_r;
  logic wstrb0_q_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [7:0] mode_r, pfm_r, pft_r;
  logic [1:0] chan_r;
  logic [9:0] result_r, pend_data_r;
  logic pend_r, conv_end_r, pf_detect_r, comparator_on_r;
  logic [10:0] settle_r;
  logic wr_fire, rd_fire, ctl_wr, rd_block, run, tmr_done, tmr_busy, settled;
  logic [9:0] store_val;

  // Registers that cost the CPU one extra bus cycle on write
  function automatic logic wr_needs_wait(input logic [7:0] a);
    return (a == apc_pkg::OFF_MODE) || (a == apc_pkg::OFF_CHAN) ||
           (a == apc_pkg::OFF_PFM) || (a == apc_pkg::OFF_PFT);
  endfunction

  // Writes that disturb the conversion in flight
  function automatic logic is_ctl(input logic [7:0] a);
    return (a == apc_pkg::OFF_MODE) || (a == apc_pkg::OFF_CHAN);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a, input logic wr);
    return wr_needs_wait(a) || (!wr && ((a == apc_pkg::OFF_RESULT) || (a == apc_pkg::OFF_STAT)));
  endfunction

  // Power-fail hit on the upper eight result bits
  function automatic logic pf_match(input logic [9:0] d, input logic [7:0] thr, input logic dir);
    return dir ? (d[9:2] < thr) : (d[9:2] >= thr);
  endfunction

  // A delayed commit is how a wait cycle shows on AXI
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r && (wwait_r || !wr_needs_wait(awaddr_q_r));
  assign rd_fire = ar_got_r && !rvalid_r && (rwait_r || araddr_q_r != apc_pkg::OFF_RESULT);
  assign ctl_wr = wr_fire && is_ctl(awaddr_q_r);
  assign rd_block = ar_got_r && (araddr_q_r == apc_pkg::OFF_RESULT);
  assign run = mode_r[apc_pkg::MODE_EN_BIT] && !standby_req;
  assign settled = (settle_r == 11'(apc_pkg::SETTLE_CYC));
  assign store_val = tmr_done ? analog_sample : pend_data_r;

  // Write channels: address and data in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      wwait_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= apc_pkg::RESP_OKAY;
      awaddr_q_r <= 8'h00;
      wdata_q_r <= 8'h00;
      wstrb0_q_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awaddr_q_r <= s_axi_awaddr;
        aw_got_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_q_r <= s_axi_wdata[7:0];
        wstrb0_q_r <= s_axi_wstrb[0];
        w_got_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= is_mapped(awaddr_q_r, 1'b1) ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        wwait_r <= 1'b0;
      end else if (aw_got_r && w_got_r && !bvalid_r) begin
        wwait_r <= 1'b1; // One wait cycle
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // Read channel; data is captured at commit so a later store cannot leak in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      ar_got_r <= 1'b0;
      rwait_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= apc_pkg::RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      araddr_q_r <= 8'h00;
    end else begin
      if (s_axi_arvalid && arready_r) begin
        araddr_q_r <= s_axi_araddr;
        ar_got_r <= 1'b1;
        arready_r <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        ar_got_r <= 1'b0;
        rwait_r <= 1'b0;
        rresp_r <= is_mapped(araddr_q_r, 1'b0) ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
        case (araddr_q_r)
          apc_pkg::OFF_MODE: rdata_r <= {24'h000000, mode_r};
          apc_pkg::OFF_CHAN: rdata_r <= {30'h00000000, chan_r};
          apc_pkg::OFF_RESULT: rdata_r <= {22'h000000, result_r};
          apc_pkg::OFF_PFM: rdata_r <= {24'h000000, pfm_r};
          apc_pkg::OFF_PFT: rdata_r <= {24'h000000, pft_r};
          apc_pkg::OFF_STAT: rdata_r <= {29'h00000000, pf_detect_r, settled, tmr_busy};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end else if (rd_block && !rvalid_r) begin
        rwait_r <= 1'b1; // One wait cycle on result reads
      end
      if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // Software-written control registers, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= apc_pkg::MODE_RST;
      chan_r <= apc_pkg::CHAN_RST;
      pfm_r <= apc_pkg::PF_RST;
      pft_r <= apc_pkg::PF_RST;
    end else if (wr_fire && wstrb0_q_r) begin
      case (awaddr_q_r)
        apc_pkg::OFF_MODE: mode_r <= wdata_q_r; // Time select change needs a halt first
        apc_pkg::OFF_CHAN: chan_r <= wdata_q_r[1:0]; // Upper bits are dropped
        apc_pkg::OFF_PFM: pfm_r <= wdata_q_r;
        apc_pkg::OFF_PFT: pft_r <= wdata_q_r;
        default: mode_r <= mode_r;
      endcase
    end
  end

  // Comparator settling time; software watches this before enabling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_r <= 11'h000;
      comparator_on_r <= 1'b0;
    end else begin
      comparator_on_r <= mode_r[apc_pkg::MODE_CMP_BIT] && !standby_req; // Off in standby
      if (!comparator_on_r) begin
        settle_r <= 11'h000;
      end else if (!settled) begin
        settle_r <= settle_r + 11'h001;
      end
    end
  end

  // A control write restarts the sequence; the old result is stale
  apc_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .restart(ctl_wr),
    .time_sel(mode_r[apc_pkg::FR_HI:apc_pkg::FR_LO]),
    .done(tmr_done),
    .busy(tmr_busy)
  );

  // Result store with access-conflict priorities
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_r <= 10'h000;
      pend_data_r <= 10'h000;
      pend_r <= 1'b0;
      conv_end_r <= 1'b0;
      pf_detect_r <= 1'b0;
    end else begin
      conv_end_r <= 1'b0;
      if (ctl_wr) begin
        pend_r <= 1'b0; // Write wins: no store, no end event
      end else if (tmr_done && rd_block) begin
        pend_r <= 1'b1; // Read wins: park the new value
        pend_data_r <= analog_sample;
      end else if (tmr_done || (pend_r && !rd_block)) begin
        result_r <= store_val; // Store; signal the end unless power-fail mode is on and there is no hit
        pend_r <= 1'b0;
        if (pfm_r[apc_pkg::PFM_EN_BIT]) begin
          pf_detect_r <= pf_match(store_val, pft_r, pfm_r[apc_pkg::PFM_DIR_BIT]);
          conv_end_r <= pf_match(store_val, pft_r, pfm_r[apc_pkg::PFM_DIR_BIT]);
        end else begin
          conv_end_r <= 1'b1;
        end
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign conv_end = conv_end_r;
  assign comparator_on = comparator_on_r;
  assign channel_sel = chan_r;
  assign pf_detect = pf_detect_r;

  // Helper: cycles between successive completions
  logic [11:0] gap_r;
  logic gap_ok_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r <= 12'h000;
      gap_ok_r <= 1'b0;
    end else begin
      gap_r <= tmr_done ? 12'h001 : gap_r + 12'h001;
      if (!run || ctl_wr) begin
        gap_ok_r <= 1'b0;
      end else if (tmr_done) begin
        gap_ok_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_ready(logic [7:0] a);
    aw_got_r && w_got_r && !bvalid_r && !wwait_r && awaddr_q_r == a;
  endsequence
  sequence s_one_wait;
    !bvalid_r ##1 bvalid_r;
  endsequence

  a_mode_wr_wait: assert property (s_wr_ready(apc_pkg::OFF_MODE) |=> s_one_wait)
    else $error("mode write without one wait cycle");
  a_chan_wr_wait: assert property (s_wr_ready(apc_pkg::OFF_CHAN) |=> s_one_wait)
    else $error("channel write without one wait cycle");
  a_pfm_wr_wait: assert property (s_wr_ready(apc_pkg::OFF_PFM) |=> s_one_wait)
    else $error("power-fail mode write without one wait cycle");
  a_pft_wr_wait: assert property (s_wr_ready(apc_pkg::OFF_PFT) |=> s_one_wait)
    else $error("threshold write without one wait cycle");
  a_result_rd_wait: assert property (rd_block && !rvalid_r && !rwait_r |=> !rvalid_r ##1 rvalid_r)
    else $error("result read without one wait cycle");
  a_conv_span: assert property (tmr_done && gap_ok_r |->
      gap_r == apc_pkg::conv_cyc(mode_r[apc_pkg::FR_HI:apc_pkg::FR_LO]))
    else $error("conversion length differs from time select");
  a_store_plain: assert property (tmr_done && !rd_block && !ctl_wr && !pfm_r[apc_pkg::PFM_EN_BIT]
      |=> conv_end_r && result_r == $past(analog_sample))
    else $error("completion did not store and signal");
  a_read_first: assert property (tmr_done && rd_block && !ctl_wr |=> result_r == $past(result_r) && pend_r)
    else $error("result changed under a pending read");
  a_write_wins: assert property (tmr_done && ctl_wr |=> !conv_end_r && result_r == $past(result_r))
    else $error("completion not dropped on control write");
  a_standby_halt: assert property (standby_req |=> !tmr_busy && !comparator_on_r)
    else $error("converter still running in standby");
endmodule
`default_nettype wire

/* verif/tb_adc_powerfail_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_adc_powerfail_control;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, standby_req = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [9:0] analog_sample = 10'h000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, channel_sel, rs;
  logic [31:0] s_axi_rdata, rd;
  logic conv_end, comparator_on, pf_detect;
  logic [7:0] a, d;
  logic [9:0] smp;
  int n_mismatch = 0;
  int n_tests = 0;
  int lat, n, e;
  localparam logic [7:0] OFFS [6] = '{apc_pkg::OFF_MODE, apc_pkg::OFF_CHAN, apc_pkg::OFF_PFM,
    apc_pkg::OFF_PFT, 8'h18, apc_pkg::OFF_RESULT};

  // Free-running 100 MHz clock
  always #5 aclk = ~aclk;

  apc_ctrl apc_ctrl_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .standby_req, .analog_sample, .conv_end, .comparator_on, .channel_sel, .pf_detect
  );

  // Edges from take to bvalid seen high; a wait cycle adds one
  function automatic int wr_lat(input logic [7:0] x);
    return (x == 8'h00 || x == 8'h04 || x == 8'h0C || x == 8'h10) ? 3 : 2;
  endfunction
  function automatic int conv_len(input int sel);
    return (apc_pkg::CONV_NS[sel] + apc_pkg::CLK_NS - 1) / apc_pkg::CLK_NS;
  endfunction
  // Value read back after writing x; unused bits come back zero
  function automatic logic [31:0] rb(input logic [7:0] x, input logic [7:0] v);
    if (x == apc_pkg::OFF_CHAN) begin
      return {30'h00000000, v[1:0]};
    end
    return (wr_lat(x) == 3) ? {24'h000000, v} : 32'h00000000;
  endfunction

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Checks that the last measured wait lies in [lo, hi]
  task automatic rng(input int lo, input int hi);
    chk({31'h00000000, n >= lo && n <= hi}, 32'h00000001);
  endtask

  task automatic axi_wr(input logic [7:0] x, input logic [7:0] v);
    bit aw_t;
    bit w_t;
    aw_t = 0;
    w_t = 0;
    lat = 0;
    @(posedge aclk);
    s_axi_awaddr <= x;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, v};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Address and data may be taken at different edges
    while (!(aw_t && w_t)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_t = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_t = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      lat++;
    end while (s_axi_bvalid !== 1'b1 && lat < 20);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] x);
    lat = 0;
    @(posedge aclk);
    s_axi_araddr <= x;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      lat++;
    end while (s_axi_rvalid !== 1'b1 && lat < 20);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Counts edges until a completion pulse, giving up after max + 1
  task automatic wait_end(input int max);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (conv_end !== 1'b1 && n <= max);
  endtask

  initial begin
    void'($urandom(32'h6491));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk({29'h00000000, conv_end, comparator_on, pf_detect}, 32'h00000000);
    // Reset values and read latency of every place but the status register
    foreach (OFFS[i]) begin
      axi_rd(OFFS[i]);
      chk(rd, 32'h00000000);
      chk(lat, OFFS[i] == apc_pkg::OFF_RESULT ? 3 : 2);
    end
    $display("Test reset done");
    // Random writes, read-only and unmapped places included
    for (int k = 0; k < 12; k++) begin
      a = OFFS[k % 6];
      d = 8'($urandom);
      if (a == apc_pkg::OFF_MODE) d = d & 8'h39;
      if (a == apc_pkg::OFF_PFM) d = d & 8'hC0;
      axi_wr(a, d);
      chk(rs, wr_lat(a) == 3 ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR);
      chk(lat, wr_lat(a));
      if (a == apc_pkg::OFF_CHAN) chk(channel_sel, d[1:0]);
      axi_rd(a);
      chk(rd, rb(a, d));
      if (a == apc_pkg::OFF_MODE) chk(comparator_on, d[0]);
    end
    axi_wr(apc_pkg::OFF_PFM, 8'h00);
    $display("Test registers done");
    // Each time code: start span, back-to-back spacing, stored value
    for (int s = 0; s < 8; s++) begin
      axi_wr(apc_pkg::OFF_MODE, 8'((s == 0 ? 0 : s - 1) << 3)); // Halt with the old time code
      smp = 10'($urandom);
      analog_sample <= smp;
      axi_wr(apc_pkg::OFF_MODE, 8'h80 | 8'(s << 3));
      e = conv_len(s) + apc_pkg::START_DLY_CYC;
      wait_end(e + 10);
      rng(e - 2, e + 3);
      wait_end(conv_len(s) + 10);
      chk(n, conv_len(s));
      axi_rd(apc_pkg::OFF_RESULT);
      chk(rd, {22'h000000, smp});
    end
    $display("Test conversion done");
    // A channel write mid-conversion restarts the sequence
    repeat (150) @(posedge aclk);
    axi_wr(apc_pkg::OFF_CHAN, 8'h02);
    e = conv_len(7) + apc_pkg::START_DLY_CYC;
    wait_end(e + 10);
    rng(e - 3, e + 3);
    $display("Test restart done");
    // Standby halts conversion and the comparator
    axi_wr(apc_pkg::OFF_MODE, 8'hB9);
    standby_req <= 1'b1;
    wait_end(3 * conv_len(7));
    chk({31'h00000000, comparator_on}, 32'h00000000);
    rng(3 * conv_len(7) + 1, 3 * conv_len(7) + 1);
    standby_req <= 1'b0;
    wait_end(e + 10);
    rng(e - 3, e + 3);
    $display("Test standby done");
    // Read outstanding as a conversion completes: old value first, new one after
    analog_sample <= ~smp;
    repeat (conv_len(7) - 4) @(posedge aclk);
    axi_rd(apc_pkg::OFF_RESULT);
    chk(rd, {22'h000000, smp});
    axi_rd(apc_pkg::OFF_RESULT);
    chk(rd, {22'h000000, ~smp});
    $display("Test read conflict done");
    // Power-fail sequence: comparator first, then mode and threshold, settle, start
    axi_wr(apc_pkg::OFF_MODE, 8'h39); // Halt, comparator on, same time code
    analog_sample <= 10'h3FF;
    axi_wr(apc_pkg::OFF_PFT, 8'hFF);
    axi_wr(apc_pkg::OFF_PFM, 8'h80);
    repeat (apc_pkg::SETTLE_CYC) @(posedge aclk);
    axi_rd(apc_pkg::OFF_STAT);
    chk(rd, 32'h00000002);
    axi_wr(apc_pkg::OFF_MODE, 8'hB9);
    wait_end(e + 10);
    rng(e - 3, e + 3); // First result already sets pf_detect
    @(posedge aclk);
    chk({31'h00000000, pf_detect}, 32'h00000001);
    analog_sample <= 10'h000;
    wait_end(2 * conv_len(7));
    rng(2 * conv_len(7) + 1, 2 * conv_len(7) + 1);
    chk({31'h00000000, pf_detect}, 32'h00000000);
    axi_rd(apc_pkg::OFF_RESULT);
    chk(rd, 32'h00000000);
    $display("Test power-fail done");
    results();
  end

  // Cuts a hang short well after the expected run length
  initial begin
    repeat (80000) @(posedge aclk);
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
